// file: lcr_cell.sv
// logic cell register with selectable asynchronous control modes
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - in preset-and-clear mode the first row control presets and the second clears.
// - in preset-and-clear mode the third lookup input is taken as one, so the first control loads a one.
// - in load-with-clear mode the first control loads the third lookup input via preset and clear.
// - in load-with-clear mode the second control clears only and never reaches the preset path.
// - in load-with-preset mode data into and out of the register are inverted, so clear acts as preset.
// - in load-with-preset mode the second control presets and the first control loads.
// - in load-with-preset mode the third lookup input is inverted so the loaded value shows uninverted.
// - in load-only mode only the first control acts, loading the third lookup input.
// - in clear-only mode either row control clears and preset stays inactive.
// - clock, clear and preset sources each select among global, pin or internal logic.
module lcr_cell (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire lcr_pkg::lcr_mode_t mode,
   input wire lcr_pkg::lcr_src_t clk_sel,
   input wire lcr_pkg::lcr_src_t ctl1_sel,
   input wire lcr_pkg::lcr_src_t ctl2_sel,
   input wire lcr_pkg::lcr_cand_t clk_cand,
   input wire lcr_pkg::lcr_cand_t ctl1_cand,
   input wire lcr_pkg::lcr_cand_t ctl2_cand,
   input wire logic lookup_input_third,
   input wire logic data_in,
   output logic q_out,
   output logic override_out
);
   logic q_r;
   logic q_nxt;
   logic clk_prev_r;
   logic clk_prev_nxt;
   logic ovr_r;
   logic ovr_nxt;

   wire logic [lcr_pkg::LCR_NUM_SEL*$bits(lcr_pkg::lcr_src_t)-1:0] sel_bus;
   wire logic [lcr_pkg::LCR_NUM_SEL*$bits(lcr_pkg::lcr_cand_t)-1:0] cand_bus;
   wire logic [lcr_pkg::LCR_NUM_SEL-1:0] src_level;
   logic reg_clk;
   logic row_control_first;
   logic row_control_second;

   logic tick;
   logic inv;
   logic mode_pc;
   logic mode_lc;
   logic mode_lp;
   logic mode_lo;
   logic mode_co;

   logic load_req;
   logic load_phys;
   logic load_pre;
   logic load_clr;
   logic side_clr;
   logic phys_q;
   logic phys_d;
   logic phys_nxt;
   logic phys_pre;
   logic phys_clr;

   // one picker per selected input: register clock, first and second control
   assign sel_bus = {ctl2_sel, ctl1_sel, clk_sel};
   assign cand_bus = {ctl2_cand, ctl1_cand, clk_cand};

   for (genvar gi = 0; gi < lcr_pkg::LCR_NUM_SEL; gi++) begin : g_src
      wire logic [$bits(lcr_pkg::lcr_src_t)-1:0] sel_one;
      wire lcr_pkg::lcr_cand_t cand_one;
      logic level_one;
      assign sel_one = sel_bus[gi*$bits(lcr_pkg::lcr_src_t) +: $bits(lcr_pkg::lcr_src_t)];
      assign cand_one = cand_bus[gi*$bits(lcr_pkg::lcr_cand_t) +: $bits(lcr_pkg::lcr_cand_t)];
      always_comb begin
         unique case (sel_one)
            lcr_pkg::LCR_SRC_GLOBAL: begin
               level_one = cand_one.from_global;
            end
            lcr_pkg::LCR_SRC_PIN: begin
               level_one = cand_one.from_pin;
            end
            lcr_pkg::LCR_SRC_LOGIC: begin
               level_one = cand_one.from_logic;
            end
            // the spare select code has no source behind it and reads as a quiet input
            default: begin
               level_one = 1'b0;
            end
         endcase
      end
      assign src_level[gi] = level_one;
   end

   assign reg_clk = src_level[lcr_pkg::LCR_SEL_CLK];
   assign row_control_first = src_level[lcr_pkg::LCR_SEL_CTL1];
   assign row_control_second = src_level[lcr_pkg::LCR_SEL_CTL2];

   // one-hot mode flags; spare codes leave all low and so drive no path
   always_comb begin
      mode_pc = (mode == lcr_pkg::LCR_MODE_PRESET_CLEAR);
      mode_lc = (mode == lcr_pkg::LCR_MODE_LOAD_CLEAR);
      mode_lp = (mode == lcr_pkg::LCR_MODE_LOAD_PRESET);
      mode_lo = (mode == lcr_pkg::LCR_MODE_LOAD_ONLY);
      mode_co = (mode == lcr_pkg::LCR_MODE_CLEAR_ONLY);
      // only load-with-preset keeps the stored bit inverted
      inv = mode_lp;
   end

   // row controls turned into the physical preset and clear paths
   always_comb begin
      load_req = 1'b0;
      load_phys = 1'b0;
      side_clr = 1'b0;
      unique case (1'b1)
         mode_pc: begin
            // a preset here is a load of a constant one
            load_req = row_control_first;
            load_phys = lcr_pkg::LCR_TIED_HIGH;
            side_clr = row_control_second;
         end
         mode_lc: begin
            load_req = row_control_first;
            load_phys = lookup_input_third;
            side_clr = row_control_second;
         end
         mode_lp: begin
            // the stored bit is inverted, so the loaded value is inverted to match
            load_req = row_control_first;
            load_phys = ~lookup_input_third;
            side_clr = row_control_second;
         end
         mode_lo: begin
            // the second control has no path into a load-only cell
            load_req = row_control_first;
            load_phys = lookup_input_third;
            side_clr = 1'b0;
         end
         mode_co: begin
            load_req = 1'b0;
            load_phys = 1'b0;
            side_clr = row_control_first | row_control_second;
         end
         default: begin
            load_req = 1'b0;
            load_phys = 1'b0;
            side_clr = 1'b0;
         end
      endcase
      // a load drives exactly one of the two physical paths
      load_pre = load_req & load_phys;
      load_clr = load_req & ~load_phys;
      phys_pre = load_pre;
      phys_clr = load_clr | side_clr;
   end

   // stored-bit group
   always_comb begin
      // the selected clock is a sampled level, so a rising edge acts at the first system clock edge that samples it high
      tick = reg_clk & ~clk_prev_r;
      phys_q = inv ? ~q_r : q_r;
      phys_d = inv ? ~data_in : data_in;
      // clear wins when both paths are driven, matching a clear-dominant cell
      // a tick lost under an override is not replayed later
      if (phys_clr) begin
         phys_nxt = 1'b0;
      end else if (phys_pre) begin
         phys_nxt = 1'b1;
      end else if (tick) begin
         phys_nxt = phys_d;
      end else begin
         phys_nxt = phys_q;
      end
      q_nxt = inv ? ~phys_nxt : phys_nxt;
   end

   // q_r keeps the logical value, so a mode change never flips what is stored
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_r <= lcr_pkg::LCR_Q_RST;
      end else if (clk_en) begin
         q_r <= q_nxt;
      end
   end

   // clock sampler group; limitation: a selected clock above half the system rate is missed
   always_comb begin
      clk_prev_nxt = reg_clk;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clk_prev_r <= lcr_pkg::LCR_CLK_PREV_RST;
      end else if (clk_en) begin
         clk_prev_r <= clk_prev_nxt;
      end
   end

   // override group: one flag per cycle in which a preset or clear path acted
   always_comb begin
      ovr_nxt = phys_clr | phys_pre;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ovr_r <= lcr_pkg::LCR_OVR_RST;
      end else if (clk_en) begin
         ovr_r <= ovr_nxt;
      end
   end

   // both outputs come straight from flops
   assign q_out = q_r;
   assign override_out = ovr_r;
endmodule
`default_nettype wire

// file: lcr_cell_props.sv
// checker: q_out against each control mode
`timescale 1ns/1ns
`default_nettype none
module lcr_cell_props (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire lcr_pkg::lcr_mode_t mode,
   input wire lcr_pkg::lcr_src_t ctl1_sel,
   input wire lcr_pkg::lcr_src_t ctl2_sel,
   input wire lcr_pkg::lcr_cand_t ctl1_cand,
   input wire lcr_pkg::lcr_cand_t ctl2_cand,
   input wire logic lookup_input_third,
   input wire logic q_out,
   input wire logic override_out
);
   // select code 3 reads as a control held low
   wire logic a = clk_en && ctl1_sel != 2'h3 && ctl1_cand[2'h2 - ctl1_sel];
   wire logic b = clk_en && ctl2_sel != 2'h3 && ctl2_cand[2'h2 - ctl2_sel];
   wire logic [4:0] md = 5'h1 << mode;
   wire logic l = lookup_input_third;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_pc_set: assert property (md[0] && a && !b |=> q_out) else $error("q");
   a_clr_path: assert property (!md[2] && !md[3] && b |=> !q_out) else $error("q");
   a_lc_load: assert property (md[1] && a && !b |=> q_out == $past(l))
      else $error("q");
   a_lo_load: assert property (md[3] && a |=> q_out == $past(l)) else $error("q");
   a_lp_set: assert property (md[2] && b |=> q_out) else $error("q");
   a_lp_load: assert property (md[2] && a && !b |=> q_out == $past(l))
      else $error("q");
   a_co_clr: assert property (md[4] && a |=> !q_out) else $error("q");
   a_en_hold: assert property (!clk_en |=> $stable(q_out)) else $error("q");
   a_ovr_set: assert property (a || b && !md[3] |=> override_out) else $error("o");
   a_ovr_idle: assert property (clk_en && !a && (!b || md[3]) |=> !override_out)
      else $error("o");
endmodule
bind lcr_cell lcr_cell_props lcr_cell_props_inst (.*);
`default_nettype wire

// file: lcr_fabric.sv
// fabric model: clock and row control candidates
`timescale 1ns/1ns
`default_nettype none
module lcr_fabric (
   input wire logic clk,
   output var lcr_pkg::lcr_cand_t clk_cand,
   output var lcr_pkg::lcr_cand_t ctl1_cand,
   output var lcr_pkg::lcr_cand_t ctl2_cand
);
   // controls kept sparse, else clock ticks rarely get through
   initial forever begin
      clk_cand = 3'($urandom);
      ctl1_cand = 3'($urandom & $urandom);
      ctl2_cand = 3'($urandom & $urandom);
      @(posedge clk) #1;
   end
endmodule
`default_nettype wire

// file: lcr_note_end.sv
// empty file: no logic of the cell lives here

// file: lcr_pkg.sv
// package: modes, source selects and reset values of the logic cell register
package lcr_pkg;
   typedef enum logic [2:0] {
      LCR_MODE_PRESET_CLEAR,
      LCR_MODE_LOAD_CLEAR,
      LCR_MODE_LOAD_PRESET,
      LCR_MODE_LOAD_ONLY,
      LCR_MODE_CLEAR_ONLY
   } lcr_mode_t;

   typedef enum logic [1:0] {
      LCR_SRC_GLOBAL,
      LCR_SRC_PIN,
      LCR_SRC_LOGIC
   } lcr_src_t;

   // one candidate of each kind for a control or clock input
   typedef struct packed {
      logic from_global;
      logic from_pin;
      logic from_logic;
   } lcr_cand_t;

   localparam logic LCR_Q_RST = 1'b0;
   localparam logic LCR_CLK_PREV_RST = 1'b0;
   localparam logic LCR_OVR_RST = 1'b0;
   localparam logic LCR_TIED_HIGH = 1'b1;
   // number of source pickers and the place of each selected input among them
   localparam int LCR_NUM_SEL = 3;
   localparam int LCR_SEL_CLK = 0;
   localparam int LCR_SEL_CTL1 = 1;
   localparam int LCR_SEL_CTL2 = 2;
endpackage

// file: tb_lcr_cell.sv
// bench: random control traffic against a reference register
`timescale 1ns/1ns
`default_nettype none
module tb_lcr_cell;
   logic clk = 1'h0, sys_rst, clk_en, lookup_input_third, data_in, q_out, eq, pk;
   logic override_out, eo;
   lcr_pkg::lcr_mode_t mode;
   lcr_pkg::lcr_src_t clk_sel, ctl1_sel, ctl2_sel;
   lcr_pkg::lcr_cand_t clk_cand, ctl1_cand, ctl2_cand;
   int n_errors = 0, num_checks = 0;
   lcr_fabric lcr_fabric_inst (.clk(clk), .clk_cand(clk_cand), .ctl1_cand(ctl1_cand),
      .ctl2_cand(ctl2_cand));
   lcr_cell lcr_cell_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .mode(mode),
      .clk_sel(clk_sel), .ctl1_sel(ctl1_sel), .ctl2_sel(ctl2_sel), .clk_cand(clk_cand),
      .ctl1_cand(ctl1_cand), .ctl2_cand(ctl2_cand), .lookup_input_third(lookup_input_third),
      .data_in(data_in), .q_out(q_out), .override_out(override_out));
   function automatic logic sel(logic [1:0] s, logic [2:0] c);
      return s != 2'h3 && c[2'h2 - s];
   endfunction
   function automatic logic nxt(logic a, logic b, logic t);
      if (b && mode != lcr_pkg::LCR_MODE_LOAD_ONLY) return mode == lcr_pkg::LCR_MODE_LOAD_PRESET;
      if (a) return mode == lcr_pkg::LCR_MODE_PRESET_CLEAR ||
         mode != lcr_pkg::LCR_MODE_CLEAR_ONLY && lookup_input_third;
      return t ? data_in : eq;
   endfunction
   task automatic chk(logic e);
      num_checks++;
      if (q_out !== e) n_errors++;
      if (q_out !== e) $display("Error %0t q_out", $time);
   endtask
   task automatic chk_ovr(logic e);
      num_checks++;
      if (override_out !== e) n_errors++;
      if (override_out !== e) $display("Error %0t override_out", $time);
   endtask
   task automatic finish_test;
      $display("errors %0d checks %0d", n_errors, num_checks);
      if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial forever #2 clk = ~clk;
   always @(posedge clk)
      if (sys_rst) {eq, pk, eo} <= 3'h0;
      else if (clk_en) {eq, pk, eo} <= {nxt(sel(ctl1_sel, ctl1_cand), sel(ctl2_sel, ctl2_cand),
         sel(clk_sel, clk_cand) & !pk), sel(clk_sel, clk_cand), sel(ctl1_sel, ctl1_cand) ||
         sel(ctl2_sel, ctl2_cand) && mode != lcr_pkg::LCR_MODE_LOAD_ONLY};
   always @(negedge clk) chk(eq);
   always @(negedge clk) chk_ovr(eo);
   initial begin
      void'($urandom(41879));
      for (int i = 0; i < 4000; i++) begin
         sys_rst = i < 5 || i % 1500 == 1499;
         clk_en = sys_rst || $urandom % 8 != 0;
         mode = lcr_pkg::lcr_mode_t'($urandom % 5);
         clk_sel = lcr_pkg::lcr_src_t'($urandom % 4);
         ctl1_sel = lcr_pkg::lcr_src_t'($urandom % 4);
         ctl2_sel = lcr_pkg::lcr_src_t'($urandom % 4);
         {lookup_input_third, data_in} = 2'($urandom);
         @(posedge clk) #1;
      end
      finish_test();
   end
endmodule
`default_nettype wire
